/* File: src/pcms_consts.vh */
`ifndef PCMS_CONSTS_VH
`define PCMS_CONSTS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PCMS_CLK_MHZ         10
`define PCMS_MASK_TIME_US    130
`define PCMS_MASK_CYCLES     (`PCMS_MASK_TIME_US * `PCMS_CLK_MHZ)
`define PCMS_BOOT_TIME_US    90
`define PCMS_BOOT_CYCLES     (`PCMS_BOOT_TIME_US * `PCMS_CLK_MHZ)
`define PCMS_STEP_CYCLES     8'h04
`define PCMS_MCLK_BASE       8'h04

// ----------------------------------------
// Codes
// ----------------------------------------
`define PCMS_BOOT_CODE       7'h20
`define PCMS_CODE_FLOOR      7'h7f

// ----------------------------------------
// Register map
// ----------------------------------------
`define PCMS_ADDR_CTRL       4'h0
`define PCMS_ADDR_STATUS     4'h4
`define PCMS_CTRL_EN_BIT     0
`define PCMS_CTRL_ON_LSB     8
`define PCMS_CTRL_ON_MSB     15
`define PCMS_ON_TIME_RST     8'h10
`define PCMS_RESP_OKAY       2'h0
`define PCMS_RESP_SLVERR     2'h2

`endif

/* File: src/pcms_period_rom.v */
`timescale 1ns/10ps
`include "pcms_consts.vh"
// ----------------------------------------
// Master clock period per voltage code
// ----------------------------------------
// Higher code means lower voltage, so the period grows and the clock slows.
module pcms_period_rom
(
   // Clock
   input  wire       aclk,
   // Lookup
   input  wire [6:0] addr,
   output reg  [7:0] rdata
);
   reg [7:0] mem [0:127];
   reg [6:0] idx;
   integer   i;

   initial
   begin
      for (i = 0; i < 128; i = i + 1)
      begin
         idx = i[6:0];
         mem[i] = `PCMS_MCLK_BASE + {3'h0, idx[6:2]};
      end
   end

   always @(posedge aclk)
   begin
      rdata <= mem[addr];
   end
endmodule

/* File: src/pcms_phase_mode_selector.v */
// Behaviour
// RULE1: Both straps low gives one phase in processor mode.
// RULE2: Lower strap low, upper high gives two phases.
// RULE3: Both straps high gives three phases.
// RULE4: Board ties straps fixed; count is static while running.
// RULE5: Each phase pulse timed independently; overlap and near full duty allowed.
// RULE6: Lower high, upper low: graphics mode, always single phase.
// RULE7: Graphics mode skips boot plateau, ramps straight to the voltage code.
// RULE8: During transient: all configured phases, clocked pulse mode, continuous conduction.
// RULE9: Hint high, sleep low: all phases, clocked pulse mode, continuous.
// RULE10: Hint low or sleep high: one phase unless current limit active; the code keeps one phase with sleep high even under limit.
// RULE11: Hint low, sleep low: ripple one phase, or all clocked under limit.
// RULE12: Sleep high: one phase; ripple with auto conduction, clocked under limit.
// RULE13: Ripple mode: phase one high drive and ramp start at threshold.
// RULE14: Ripple mode: high drive ends when ramp reaches error amplifier.
// RULE15: Ripple mode: low side off once inductor current reaches zero.
// RULE16: Clocked mode: per-phase rate is master clock over phases in use.
// RULE17: Master clock constant per code, slower for lower coded voltage.
// RULE18: Any code or deeper sleep change starts a transient period; the code starts one only while running.
// RULE19: Transient lasts about 130 us, extended on excessive output drop.
// RULE20: Inactive phases hold their pulse outputs off.
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`include "pcms_consts.vh"
module pcms_phase_mode_selector
(
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // Straps and system pins
   input  wire        phase_strap_lo,
   input  wire        phase_strap_hi,
   input  wire        power_state_hint,
   input  wire        deeper_sleep_req,
   input  wire        enable,
   input  wire [6:0]  voltage_code,
   input  wire        current_limit,
   // Analog comparator results
   input  wire        comp_at_threshold,
   input  wire        ramp_at_comp,
   input  wire        inductor_zero,
   input  wire        output_drop_excess,
   // Power stage
   output reg  [2:0]  high_drive,
   output reg  [2:0]  low_drive,
   output reg         ramp_start,
   // Status
   output reg  [1:0]  active_phases,
   output reg         ripple_pulse_mode,
   output reg         ccm_only,
   output reg         graphics_single_phase_mode,
   output reg         power_good_mask,
   output reg  [6:0]  dac_code,
   // AXI4-Lite write
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_RAMP = 2'h1;
   localparam [1:0] ST_BOOT = 2'h2;
   localparam [1:0] ST_RUN  = 2'h3;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   wire [16:0] pin_raw = {output_drop_excess, inductor_zero, ramp_at_comp,
                          comp_at_threshold, current_limit, voltage_code, enable,
                          deeper_sleep_req, power_state_hint, phase_strap_hi,
                          phase_strap_lo};
   reg  [16:0] pin_s1;
   reg  [16:0] pin_s2;
   reg         thr_prev;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_s1   <= 17'h00000;
         pin_s2   <= 17'h00000;
         thr_prev <= 1'b0;
      end
      else
      begin
         pin_s1   <= pin_raw;
         pin_s2   <= pin_s1;
         thr_prev <= pin_s2[13];
      end
   end

   wire       strap_lo  = pin_s2[0];
   wire       strap_hi  = pin_s2[1];
   wire       hint      = pin_s2[2];
   wire       dslp      = pin_s2[3];
   wire       pin_en    = pin_s2[4];
   wire [6:0] code      = pin_s2[11:5];
   wire       ilim      = pin_s2[12];
   wire       thr_rise  = pin_s2[13] & ~thr_prev;
   wire       ramp_hit  = pin_s2[14];
   wire       izero     = pin_s2[15];
   wire       drop_big  = pin_s2[16];

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg        sw_enable;
   reg [7:0]  on_time;
   reg [1:0]  state;
   reg [1:0]  cfg_phases;
   reg        transient;
   reg [11:0] trans_cnt;
   reg [6:0]  code_prev;
   reg        dslp_prev;

   wire running = (state != ST_IDLE);

   // ----------------------------------------
   // Strap capture
   // ----------------------------------------
   // Straps are sampled only while idle, as the board keeps them fixed
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg_phases                 <= 2'h1;
         graphics_single_phase_mode <= 1'b0;
      end
      else if (state == ST_IDLE) // RULE4
      begin
         graphics_single_phase_mode <= strap_lo & ~strap_hi; // RULE6
         case ({strap_hi, strap_lo})
            2'b00:   cfg_phases <= 2'h1; // RULE1
            2'b01:   cfg_phases <= 2'h1; // RULE6
            2'b10:   cfg_phases <= 2'h2; // RULE2
            2'b11:   cfg_phases <= 2'h3; // RULE3
            default: cfg_phases <= 2'h1;
         endcase
      end
   end

   // ----------------------------------------
   // Transient period
   // ----------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         transient <= 1'b0;
         trans_cnt <= 12'h000;
         code_prev <= 7'h00;
         dslp_prev <= 1'b0;
      end
      else
      begin
         code_prev <= code;
         dslp_prev <= dslp;
         if (running && (code != code_prev || dslp != dslp_prev)) // RULE18
         begin
            transient <= 1'b1;
            trans_cnt <= 12'h000;
         end
         else if (transient)
         begin
            if (drop_big)
               trans_cnt <= 12'h000; // RULE19
            else if (trans_cnt == `PCMS_MASK_CYCLES - 1)
               transient <= 1'b0; // RULE19
            else
               trans_cnt <= trans_cnt + 12'h001;
         end
      end
   end

   // ----------------------------------------
   // Phase count and modulation choice
   // ----------------------------------------
   reg [1:0] next_active;
   reg       next_ripple;
   reg       next_ccm;

   always @*
   begin
      next_active = cfg_phases;
      next_ripple = 1'b0;
      next_ccm    = 1'b1;
      if (transient)
         next_active = cfg_phases; // RULE8
      else if (hint && !dslp)
         next_active = cfg_phases; // RULE9
      else if (!dslp)
      begin
         if (!ilim) // RULE10
         begin
            next_active = 2'h1; // RULE11
            next_ripple = 1'b1;
         end
      end
      else
      begin
         next_active = 2'h1; // RULE12
         next_ripple = ~ilim;
         next_ccm    = ilim;
      end
      if (graphics_single_phase_mode)
         next_active = 2'h1; // RULE6
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         active_phases     <= 2'h1;
         ripple_pulse_mode <= 1'b0;
         ccm_only          <= 1'b1;
         power_good_mask   <= 1'b0;
      end
      else
      begin
         active_phases     <= next_active;
         ripple_pulse_mode <= next_ripple & running;
         ccm_only          <= next_ccm;
         power_good_mask   <= transient;
      end
   end

   // ----------------------------------------
   // Soft start sequencer
   // ----------------------------------------
   reg [7:0]  step_cnt;
   reg [11:0] boot_cnt;
   wire [6:0] ramp_target = (state == ST_RAMP && !graphics_single_phase_mode) ?
                            `PCMS_BOOT_CODE : code;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state    <= ST_IDLE;
         dac_code <= `PCMS_CODE_FLOOR;
         step_cnt <= 8'h00;
         boot_cnt <= 12'h000;
      end
      else if (!(pin_en && sw_enable))
      begin
         state    <= ST_IDLE;
         dac_code <= `PCMS_CODE_FLOOR;
      end
      else
      begin
         // Codes step one at a time so the output never jumps while enabled
         if (state != ST_IDLE && state != ST_BOOT)
         begin
            if (step_cnt == `PCMS_STEP_CYCLES - 8'h01)
            begin
               step_cnt <= 8'h00;
               if (dac_code > ramp_target)
                  dac_code <= dac_code - 7'h01;
               else if (dac_code < ramp_target)
                  dac_code <= dac_code + 7'h01;
            end
            else
               step_cnt <= step_cnt + 8'h01;
         end
         case (state)
            ST_IDLE:
               state <= ST_RAMP;
            ST_RAMP:
               if (dac_code == ramp_target)
               begin
                  boot_cnt <= 12'h000;
                  state    <= graphics_single_phase_mode ? ST_RUN : ST_BOOT; // RULE7
               end
            ST_BOOT:
               if (boot_cnt == `PCMS_BOOT_CYCLES - 1)
                  state <= ST_RUN;
               else
                  boot_cnt <= boot_cnt + 12'h001;
            ST_RUN:
               state <= ST_RUN;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Master clock and phase rotation
   // ----------------------------------------
   wire [7:0] period;
   reg  [7:0] mclk_cnt;
   reg  [1:0] slot;
   reg  [2:0] fire;

   pcms_period_rom u_period_rom
   (
      .aclk  (aclk),
      .addr  (dac_code), // RULE17
      .rdata (period)
   );

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mclk_cnt <= 8'h00;
         slot     <= 2'h0;
         fire     <= 3'h0;
      end
      else
      begin
         fire <= 3'h0;
         if (!running || ripple_pulse_mode)
         begin
            mclk_cnt <= 8'h00;
            slot     <= 2'h0;
         end
         else if (mclk_cnt >= period - 8'h01)
         begin
            // One tick per master period, handed round the phases in use
            mclk_cnt   <= 8'h00;
            fire[slot] <= 1'b1; // RULE16
            slot       <= (slot + 2'h1 >= active_phases) ? 2'h0 : slot + 2'h1;
         end
         else
            mclk_cnt <= mclk_cnt + 8'h01;
      end
   end

   // ----------------------------------------
   // Per-phase drives
   // ----------------------------------------
   reg zero_seen;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         zero_seen  <= 1'b0;
         ramp_start <= 1'b0;
      end
      else
      begin
         ramp_start <= ripple_pulse_mode & thr_rise; // RULE13
         if (ripple_pulse_mode && izero)
            zero_seen <= 1'b1; // RULE15
         else if (high_drive[0] || !ripple_pulse_mode)
            zero_seen <= 1'b0;
      end
   end

   genvar k;
   generate
      for (k = 0; k < 3; k = k + 1)
      begin : g_phase
         reg  [7:0] on_cnt;
         reg        next_hd;
         wire       live = running && (k < active_phases);

         always @*
         begin
            next_hd = high_drive[k];
            if (!live)
               next_hd = 1'b0; // RULE20
            else if (ripple_pulse_mode && k == 0)
            begin
               if (thr_rise)
                  next_hd = 1'b1; // RULE13
               else if (ramp_hit)
                  next_hd = 1'b0; // RULE14
            end
            else if (ripple_pulse_mode)
               next_hd = 1'b0;
            else if (fire[k])
               next_hd = 1'b1; // RULE5
            else if (on_cnt + 8'h01 >= on_time)
               next_hd = 1'b0; // RULE5
         end

         // Each phase keeps its own on-time count, so pulses may overlap
         always @(posedge aclk)
         begin
            if (!aresetn)
            begin
               on_cnt        <= 8'h00;
               high_drive[k] <= 1'b0;
               low_drive[k]  <= 1'b0;
            end
            else
            begin
               on_cnt        <= (fire[k] || !high_drive[k]) ? 8'h00 : on_cnt + 8'h01;
               high_drive[k] <= next_hd;
               low_drive[k]  <= live & ~next_hd &
                                ~(k == 0 && ripple_pulse_mode && (zero_seen || izero)); // RULE15
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   reg        aw_held;
   reg        w_held;
   reg [3:0]  aw_addr;
   reg [31:0] w_data;
   reg [3:0]  w_strb;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 4'h0;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PCMS_RESP_OKAY;
         sw_enable     <= 1'b0;
         on_time       <= `PCMS_ON_TIME_RST;
      end
      else
      begin
         s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_held && w_held && !s_axi_bvalid)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == `PCMS_ADDR_CTRL)
            begin
               s_axi_bresp <= `PCMS_RESP_OKAY;
               if (w_strb[0])
                  sw_enable <= w_data[`PCMS_CTRL_EN_BIT];
               if (w_strb[1])
                  on_time <= w_data[`PCMS_CTRL_ON_MSB:`PCMS_CTRL_ON_LSB];
            end
            else
               s_axi_bresp <= `PCMS_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `PCMS_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `PCMS_RESP_OKAY;
            case (s_axi_araddr)
               `PCMS_ADDR_CTRL:
                  s_axi_rdata <= {16'h0000, on_time, 7'h00, sw_enable};
               `PCMS_ADDR_STATUS:
                  s_axi_rdata <= {9'h000, dac_code, 6'h00, state, ccm_only,
                                  transient, graphics_single_phase_mode,
                                  ripple_pulse_mode, active_phases, cfg_phases};
               default:
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `PCMS_RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule

/* File: testbench/pcms_stage_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Power stage and error amplifier
// ----------------------------------------
// Ripple threshold every 40 clocks; current reaches zero 10 clocks into low side
module pcms_stage_model
(
   // Clock
   input  wire       aclk,
   // Drives
   input  wire [2:0] high_drive,
   input  wire [2:0] low_drive,
   // Comparators
   output reg        comp_at_threshold,
   output reg        ramp_at_comp,
   output reg        inductor_zero
);
   reg [5:0] tick = 6'h00;
   reg [3:0] lo_cnt = 4'h0;
   initial {comp_at_threshold, ramp_at_comp, inductor_zero} = 3'h0;
   always @(posedge aclk)
   begin
      tick <= (tick == 6'h27) ? 6'h00 : tick + 6'h01;
      comp_at_threshold <= (tick < 6'h03);
      ramp_at_comp <= high_drive[0] && tick > 6'h08 && tick < 6'h10;
      lo_cnt <= low_drive[0] ? lo_cnt + {3'h0, lo_cnt != 4'hf} : 4'h0;
      // Current stays at zero until the next high-side pulse
      inductor_zero <= !high_drive[0] && (inductor_zero || lo_cnt > 4'h8);
   end
endmodule

/* File: testbench/pcms_checker_assertions.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Mode and drive checks
// ----------------------------------------
module pcms_checker
(
   // Clock and reset
   input wire       aclk,
   input wire       aresetn,
   // Comparators
   input wire       ramp_at_comp,
   input wire       inductor_zero,
   // Drives and status
   input wire [2:0] high_drive,
   input wire [2:0] low_drive,
   input wire       ramp_start,
   input wire [1:0] active_phases,
   input wire       ripple_pulse_mode,
   input wire       ccm_only,
   input wire       graphics_single_phase_mode,
   input wire       power_good_mask
);
   default clocking dcb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Mask and mode register from transient on the same edge; judge inside the window
   sequence s_mask_run;
      power_good_mask [*3];
   endsequence
   sequence s_zero_run;
      (ripple_pulse_mode && inductor_zero) [*5];
   endsequence
   a_graphics_one_phase: assert property (
      graphics_single_phase_mode [*3] |-> active_phases == 2'h1)
      else $error("graphics mode on several phases");
   a_single_rest_off: assert property (
      (active_phases == 2'h1) [*4] |-> high_drive[2:1] == 2'h0)
      else $error("idle phase driven");
   a_dual_third_off: assert property (
      (active_phases == 2'h2) [*4] |-> !high_drive[2])
      else $error("third phase driven");
   a_transient_all_clocked: assert property (
      s_mask_run |-> $past(!ripple_pulse_mode && ccm_only))
      else $error("ripple during transient");
   a_ripple_one_phase: assert property (
      ripple_pulse_mode [*2] |-> active_phases == 2'h1)
      else $error("ripple on several phases");
   a_auto_only_ripple: assert property (
      !ccm_only [*2] |-> ripple_pulse_mode && active_phases == 2'h1)
      else $error("auto conduction outside ripple");
   a_ramp_with_drive: assert property (
      ramp_start |-> ##[0:1] high_drive[0])
      else $error("ramp start without high drive");
   a_ramp_ends_drive: assert property (
      ripple_pulse_mode && high_drive[0] && ramp_at_comp |-> ##[1:5] !high_drive[0])
      else $error("high drive outlives ramp");
   a_zero_cuts_low: assert property (
      s_zero_run |-> !low_drive[0])
      else $error("low side on at zero current");
endmodule
bind pcms_phase_mode_selector pcms_checker u_chk (.aclk, .aresetn, .ramp_at_comp,
   .inductor_zero, .high_drive, .low_drive, .ramp_start, .active_phases,
   .ripple_pulse_mode, .ccm_only, .graphics_single_phase_mode, .power_good_mask);

/* File: testbench/pcms_testbench.sv */
`timescale 1ns/10ps
`define PCMS_CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ----------------------------------------
// Bench top
// ----------------------------------------
module testbench;
   logic        aclk = 1'b0, aresetn = 1'b0, enable = 1'b0, current_limit = 1'b0;
   logic        phase_strap_lo = 1'b0, phase_strap_hi = 1'b0, output_drop_excess = 1'b0;
   logic        power_state_hint = 1'b0, deeper_sleep_req = 1'b0;
   logic [6:0]  voltage_code = 7'h10;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0, st;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [1:0]  rr;
   int          failures = 0, checks_done = 0;
   wire         comp_at_threshold, ramp_at_comp, inductor_zero, ramp_start;
   wire         ripple_pulse_mode, ccm_only, graphics_single_phase_mode, power_good_mask;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [2:0]   high_drive, low_drive;
   wire [1:0]   active_phases, s_axi_bresp, s_axi_rresp;
   wire [6:0]   dac_code;
   wire [31:0]  s_axi_rdata;

   pcms_phase_mode_selector u_dut (.*);
   pcms_stage_model u_stage (.*);

   initial
   begin
      forever #50 aclk = ~aclk;
   end

   task give_verdict;
      if (failures == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task stop_run;
      failures++;
      give_verdict;
   endtask
   task automatic clk(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wait_dac(input logic [6:0] c, input int lim);
      int n;
      for (n = 0; n < lim && dac_code !== c; n++)
         @(negedge aclk);
      if (n >= lim) stop_run;
   endtask
   task automatic wait_mask;
      int n;
      for (n = 0; n < 3000 && power_good_mask !== 1'b0; n++)
         @(negedge aclk);
      if (n >= 3000) stop_run;
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50 && (s_axi_awvalid || s_axi_wvalid || s_axi_bvalid !== 1'b1); n++)
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      if (n >= 50) stop_run;
      `PCMS_CHK(s_axi_bresp, e)
   endtask
   task automatic axi_rd(input logic [3:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50 && (s_axi_arvalid || s_axi_rvalid !== 1'b1); n++)
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      st = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 50) stop_run;
   endtask
   // Cycles until the next fresh rise of one phase's high drive
   task automatic rise(input int k, inout int n);
      logic p;
      p = 1'b1;
      for (int j = 0; j < 400; j++)
      begin
         @(negedge aclk);
         n++;
         if (high_drive[k] === 1'b1 && !p) return;
         p = high_drive[k];
      end
      stop_run;
   endtask
   // {phases, ripple, ccm} for three configured phases, v = {hint, sleep, limit}
   function automatic logic [3:0] mode_of(input logic [2:0] v);
      if (v[1]) return {2'h1, !v[0], v[0]};
      if (!v[2] && !v[0]) return 4'h7;
      return 4'hd;
   endfunction

   task automatic t_regs;
      axi_rd(4'h0);
      `PCMS_CHK({rr, st}, {2'h0, 32'h00001000})
      axi_rd(4'h8);
      `PCMS_CHK({rr, st}, {2'h2, 32'h0})
      axi_wr(4'h4, 32'h0, 2'h2);
      axi_wr(4'h0, 32'h00001001, 2'h0);
   endtask
   task automatic t_straps;
      logic [1:0] cfg [4];
      cfg = '{2'h1, 2'h1, 2'h2, 2'h3};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge aclk);
         {power_state_hint, phase_strap_hi, phase_strap_lo} <= {1'b1, i[1:0]};
         clk(6);
         axi_rd(4'h4);
         `PCMS_CHK(st[1:0], cfg[i])
         `PCMS_CHK({st[5], graphics_single_phase_mode}, {2{i == 1}})
      end
   endtask
   task automatic t_cpu_start;
      @(posedge aclk);
      enable <= 1'b1;
      wait_dac(7'h20, 600);
      clk(100);
      axi_rd(4'h4);
      `PCMS_CHK(st[9:8], 2'h2)
      wait_dac(7'h10, 1200);
      wait_mask;
   endtask
   task automatic t_modes;
      logic [2:0] v;
      logic       prev;
      int         k;
      for (int i = 0; i < 8; i++)
      begin
         v = i[2:0];
         prev = deeper_sleep_req;
         @(posedge aclk);
         {power_state_hint, deeper_sleep_req, current_limit} <= v;
         clk(8);
         @(negedge aclk);
         `PCMS_CHK(power_good_mask, prev ^ v[1])
         if (power_good_mask === 1'b1)
            `PCMS_CHK({active_phases, ripple_pulse_mode, ccm_only}, 4'hd)
         wait_mask;
         clk(4);
         @(negedge aclk);
         `PCMS_CHK({active_phases, ripple_pulse_mode, ccm_only}, mode_of(v))
         k = 0;
         for (int j = 0; j < 200 && v == 3'h0; j++)
         begin
            @(negedge aclk);
            k += (ramp_start === 1'b1);
            `PCMS_CHK(high_drive[2:1], 2'h0)
         end
         `PCMS_CHK(k > 2, v == 3'h0)
      end
   endtask
   task automatic t_clocked;
      logic [6:0] c;
      int         n;
      @(posedge aclk);
      {power_state_hint, deeper_sleep_req, current_limit} <= 3'h4;
      for (int i = 0; i < 2; i++)
      begin
         c = i ? 7'h40 : 7'h10;
         @(posedge aclk);
         voltage_code <= c;
         clk(8);
         wait_mask;
         wait_dac(c, 300);
         n = 0;
         rise(0, n);
         n = 0;
         rise(1, n);
         `PCMS_CHK(n, 4 + c[6:2])
         rise(2, n);
         rise(0, n);
         `PCMS_CHK(n, 3 * (4 + c[6:2]))
      end
   endtask
   task automatic t_transient;
      int n;
      for (int i = 0; i < 2; i++)
      begin
         @(posedge aclk);
         voltage_code <= i ? 7'h28 : 7'h30;
         for (n = 0; n < 20 && power_good_mask !== 1'b1; n++)
            @(negedge aclk);
         if (n >= 20) stop_run;
         for (n = 0; n < 3000 && power_good_mask === 1'b1; n++)
         begin
            @(posedge aclk);
            output_drop_excess <= (i == 1 && n >= 100 && n < 103);
            @(negedge aclk);
         end
         `PCMS_CHK(i ? (n > 1400 && n < 1416) : n == 1300, 1'b1)
      end
   endtask
   task automatic t_graphics;
      @(posedge aclk);
      aresetn <= 1'b0;
      {phase_strap_hi, phase_strap_lo} <= 2'h1;
      voltage_code <= 7'h60;
      clk(3);
      aresetn <= 1'b1;
      clk(4);
      axi_wr(4'h0, 32'h00001001, 2'h0);
      wait_dac(7'h60, 300);
      clk(20);
      axi_rd(4'h4);
      `PCMS_CHK({st[9:8], active_phases}, {2'h3, 2'h1})
   endtask

   initial
   begin
      clk(2);
      aresetn <= 1'b1;
      t_regs;
      t_straps;
      t_cpu_start;
      t_modes;
      t_clocked;
      t_transient;
      t_graphics;
      give_verdict;
   end
endmodule
